// *** wmc_top.sv ***
// warm-up counter and operation mode controller with wishbone registers
// What this block does
// - mode moves that start an oscillator wait until the warm-up is over
// - source select 00 internal hf, 01 external hf, 10 lf clock
// - divide code 00..11 feeds the counter with source over 1, 2, 4, 8
// - setting an oscillator enable starts it and starts the 14-stage count
// - only a 0-to-1 change of an enable starts counting
// - upper 8 counter bits equal compare: irq, stop, clear counter
// - abort write stops the count, clears counter, abort bit reads 0
// - abort leaves enables alone; software clears then sets to restart
// - after reset single-clock run with internal hf as reference
// - single-clock machine cycle is one gear clock period
// - dual-clock: gear clock in run and doze, four lf periods in slow
// - internal hf reference releases the external hf pins as gpio
// - lf pins are gpio in single-clock mode, oscillator in dual-clock
// - idle request in single run stops cpu and watchdog only
// - enabled interrupt latch ends doze and returns to single run, dual run or slow with hf stopped
// - halt request in single run or slow with hf stopped stops cpu and gates peripherals except timebase
// - falling edge of timebase source ends halt, back to single run or slow with hf stopped
// - timebase enabled at halt entry sets its irq latch on return
// - hf reference select is frozen while slow clock select is 1
// - slow select switches dual run and slow with hf, prescaler stops
// - either hf enable (internal or external) switches slow with hf stopped and running
module wmc_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        int_hf_clk_i,
  input  wire logic        ext_hf_clk_i,
  input  wire logic        lf_clk_i,
  input  wire logic        tb_src_clk_i,
  input  wire logic        timebase_enable_i,
  input  wire logic        irq_pending_i,
  output logic             warmup_done_irq_o,
  output logic             timebase_irq_set_o,
  output logic             int_hf_osc_en_o,
  output logic             ext_hf_osc_en_o,
  output logic             lf_osc_en_o,
  output logic             hf_ref_ext_o,
  output logic             mc_from_lf_o,
  output logic             cpu_stop_o,
  output logic             wdt_stop_o,
  output logic             periph_gate_o,
  output logic             prescaler_stop_o,
  output logic             hf_pins_gpio_o,
  output logic             lf_pins_gpio_o
);

  function automatic logic [2:0] div_mask(input logic [1:0] d);
    div_mask = 3'(( 4'h1 << d ) - 4'h1);
  endfunction

  function automatic logic is_slow(input wmc_pkg::wmc_mode_t m);
    is_slow = (m == wmc_pkg::ST_SLOW_HF_STOPPED) || (m == wmc_pkg::ST_SLOW_HF_RUNNING) ||
              (m == wmc_pkg::ST_SLOW_DOZE) || (m == wmc_pkg::ST_SLOW_HALT);
  endfunction

  function automatic logic is_single(input wmc_pkg::wmc_mode_t m);
    is_single = (m == wmc_pkg::ST_S_RUN) || (m == wmc_pkg::ST_S_DOZE) ||
                (m == wmc_pkg::ST_S_HALT);
  endfunction

  // bus
  logic                          ack_r;
  logic [31:0]                   rdat_r;
  // registers
  wmc_pkg::wmc_wctl_t            wctl_r;
  logic [wmc_pkg::CMP_W-1:0]     cmp_r;
  logic                          hfsel_r;
  wmc_pkg::wmc_sc2_t             sc2_r;
  // warm-up counter
  logic                          busy_r;
  logic [wmc_pkg::PRE_W-1:0]     pre_r;
  logic [wmc_pkg::CNT_W-1:0]     cnt_r;
  logic                          wirq_r;
  // mode
  wmc_pkg::wmc_mode_t            state_r;
  wmc_pkg::wmc_mode_t            state_nxt;
  logic                          tben_r;
  logic                          tbirq_r;
  // synchronisers for the oscillator and timebase clocks
  logic [wmc_pkg::NSYNC-1:0]     s1_r;
  logic [wmc_pkg::NSYNC-1:0]     s2_r;
  logic [wmc_pkg::NSYNC-1:0]     s3_r;
  logic [wmc_pkg::NSYNC-1:0]     lvl_r;
  logic [wmc_pkg::NSYNC-1:0]     rise_w;
  logic [wmc_pkg::NSYNC-1:0]     fall_w;
  logic [wmc_pkg::NSYNC-1:0]     raw_w;
  logic [wmc_pkg::NSYNC-1:0]     lvl_nxt;

  assign raw_w = {tb_src_clk_i, lf_clk_i, ext_hf_clk_i, int_hf_clk_i};

  // three flops; a level counts once the second and third agree
  genvar g;
  generate
    for (g = 0; g < wmc_pkg::NSYNC; g++) begin : g_sync
      assign lvl_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : lvl_r[g];
      assign rise_w[g]  = lvl_nxt[g] & ~lvl_r[g];
      assign fall_w[g]  = ~lvl_nxt[g] & lvl_r[g];
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s1_r[g]  <= 1'b0;
          s2_r[g]  <= 1'b0;
          s3_r[g]  <= 1'b0;
          lvl_r[g] <= 1'b0;
        end else begin
          s1_r[g]  <= raw_w[g];
          s2_r[g]  <= s1_r[g];
          s3_r[g]  <= s2_r[g];
          lvl_r[g] <= lvl_nxt[g];
        end
      end
    end
  endgenerate

  // bus decode; writes commit on the edge that sees ack high
  logic wr_w;
  logic wr_wctl;
  logic wr_wcmp;
  logic wr_sc1;
  logic wr_sc2;
  logic [7:0] wd;
  assign wd      = wb_dat_i[7:0];
  assign wr_w    = wb_cyc_i & wb_stb_i & wb_we_i & ack_r & wb_sel_i[0];
  assign wr_wctl = wr_w & (wb_adr_i == wmc_pkg::OFF_WCTL);
  assign wr_wcmp = wr_w & (wb_adr_i == wmc_pkg::OFF_WCMP);
  assign wr_sc1  = wr_w & (wb_adr_i == wmc_pkg::OFF_SC1);
  assign wr_sc2  = wr_w & (wb_adr_i == wmc_pkg::OFF_SC2);

  // control events from writes
  logic       abort_w;
  logic       start_w;
  logic       idle_req;
  logic       halt_req;
  logic [2:0] en_new;
  logic [2:0] en_old;
  assign abort_w  = wr_wctl & wd[wmc_pkg::WCTL_ABORT];
  assign en_new   = {wd[wmc_pkg::SC2_INT_EN], wd[wmc_pkg::SC2_EXT_EN],
                     wd[wmc_pkg::SC2_LF_EN]};
  assign en_old   = {sc2_r.int_en, sc2_r.ext_en, sc2_r.lf_en};
  assign start_w  = wr_sc2 & |(en_new & ~en_old);
  assign idle_req = wr_sc2 & wd[wmc_pkg::SC2_IDLE];
  assign halt_req = wr_sc2 & wd[wmc_pkg::SC2_HALT];

  // readback; abort bit is never stored so it reads 0
  logic [31:0] rd_w;
  logic [31:0] stat_w;
  logic        hf_on;
  assign hf_on  = sc2_r.int_en | sc2_r.ext_en;
  assign stat_w = {16'h0000, cnt_r[wmc_pkg::CNT_W-1 -: wmc_pkg::CMP_W],
                   5'h00, is_slow(state_r), ~is_single(state_r), busy_r};
  always_comb begin
    rd_w = 32'h0000_0000; // unmapped addresses read zero
    unique case (wb_adr_i)
      wmc_pkg::OFF_WCTL: rd_w = {28'h0, wctl_r};
      wmc_pkg::OFF_WCMP: rd_w = {24'h0, cmp_r};
      wmc_pkg::OFF_SC1:  rd_w = {28'h0, hfsel_r, 3'h0};
      wmc_pkg::OFF_SC2:  rd_w = {24'h0, sc2_r.int_en, sc2_r.ext_en,
                                 sc2_r.lf_en, sc2_r.sck,
                                 state_r == wmc_pkg::ST_S_DOZE ||
                                 state_r == wmc_pkg::ST_D_DOZE ||
                                 state_r == wmc_pkg::ST_SLOW_DOZE,
                                 state_r == wmc_pkg::ST_S_HALT ||
                                 state_r == wmc_pkg::ST_SLOW_HALT, 2'h0};
      wmc_pkg::OFF_STAT: rd_w = stat_w;
      default:           rd_w = 32'h0000_0000;
    endcase
  end

  // single-wait-state slave: ack one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r  <= wb_cyc_i & wb_stb_i & ~ack_r;
      rdat_r <= rd_w;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // software registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wctl_r  <= '{div: wmc_pkg::RST_DIV, sel: wmc_pkg::RST_SEL};
      cmp_r   <= wmc_pkg::RST_CMP;
      hfsel_r <= wmc_pkg::RST_HFSEL;
      sc2_r   <= '{int_en: wmc_pkg::RST_INTEN, default: 1'b0};
    end else begin
      if (wr_wctl) begin
        wctl_r.sel <= wd[wmc_pkg::WCTL_SEL_LSB +: 2];
        wctl_r.div <= wd[wmc_pkg::WCTL_DIV_LSB +: 2];
      end
      if (wr_wcmp)
        cmp_r <= wd;
      // reference select frozen while slow clock is selected
      if (wr_sc1 && !sc2_r.sck)
        hfsel_r <= wd[wmc_pkg::SC1_HFSEL];
      // abort does not touch the enables
      if (wr_sc2) begin
        sc2_r.int_en <= wd[wmc_pkg::SC2_INT_EN];
        sc2_r.ext_en <= wd[wmc_pkg::SC2_EXT_EN];
        sc2_r.lf_en  <= wd[wmc_pkg::SC2_LF_EN];
        sc2_r.sck    <= wd[wmc_pkg::SC2_SCK];
      end
    end
  end

  // warm-up: selected source edge, 3-stage divider, 14-stage counter
  logic src_edge;
  logic tick_w;
  logic match_w;
  assign src_edge = (wctl_r.sel == wmc_pkg::SRC_INT_HF) ? rise_w[0] :
                    (wctl_r.sel == wmc_pkg::SRC_EXT_HF) ? rise_w[1] :
                    (wctl_r.sel == wmc_pkg::SRC_LF)     ? rise_w[2] :
                    1'b0;
  assign tick_w  = src_edge &
                   ((pre_r & div_mask(wctl_r.div)) ==
                    div_mask(wctl_r.div));
  assign match_w = busy_r &
                   (cnt_r[wmc_pkg::CNT_W-1 -: wmc_pkg::CMP_W] == cmp_r);

  // abort wins over start and match; a restart needs a fresh 0-to-1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
      pre_r  <= '0;
      cnt_r  <= '0;
      wirq_r <= 1'b0;
    end else begin
      wirq_r <= 1'b0;
      if (abort_w) begin
        busy_r <= 1'b0;
        pre_r  <= '0;
        cnt_r  <= '0;
      end else if (start_w) begin
        busy_r <= 1'b1;
        pre_r  <= '0;
        cnt_r  <= '0;
      end else if (match_w) begin
        busy_r <= 1'b0;
        cnt_r  <= '0;
        pre_r  <= '0;
        wirq_r <= 1'b1;
      end else if (busy_r && src_edge) begin
        pre_r <= pre_r + 3'h1;
        if (tick_w)
          cnt_r <= cnt_r + 14'h0001;
      end
    end
  end

  // mode transitions; oscillator-starting moves wait for warm-up end
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      wmc_pkg::ST_S_RUN: begin
        if (halt_req)
          state_nxt = wmc_pkg::ST_S_HALT;
        else if (idle_req)
          state_nxt = wmc_pkg::ST_S_DOZE;
        else if (sc2_r.lf_en && !busy_r && !start_w)
          state_nxt = wmc_pkg::ST_D_RUN;
      end
      wmc_pkg::ST_S_DOZE:
        if (irq_pending_i)
          state_nxt = wmc_pkg::ST_S_RUN;
      wmc_pkg::ST_S_HALT:
        if (fall_w[wmc_pkg::SRC_TB])
          state_nxt = wmc_pkg::ST_S_RUN;
      wmc_pkg::ST_D_RUN: begin
        if (!sc2_r.lf_en)
          state_nxt = wmc_pkg::ST_S_RUN;
        else if (idle_req)
          state_nxt = wmc_pkg::ST_D_DOZE;
        else if (sc2_r.sck && !busy_r)
          state_nxt = wmc_pkg::ST_SLOW_HF_RUNNING;
      end
      wmc_pkg::ST_D_DOZE:
        if (irq_pending_i)
          state_nxt = wmc_pkg::ST_D_RUN;
      wmc_pkg::ST_SLOW_HF_RUNNING: begin
        if (!sc2_r.sck)
          state_nxt = wmc_pkg::ST_D_RUN;
        else if (!hf_on)
          state_nxt = wmc_pkg::ST_SLOW_HF_STOPPED;
      end
      wmc_pkg::ST_SLOW_HF_STOPPED: begin
        if (halt_req)
          state_nxt = wmc_pkg::ST_SLOW_HALT;
        else if (idle_req)
          state_nxt = wmc_pkg::ST_SLOW_DOZE;
        else if (hf_on && !busy_r && !start_w)
          state_nxt = wmc_pkg::ST_SLOW_HF_RUNNING;
      end
      wmc_pkg::ST_SLOW_DOZE:
        if (irq_pending_i)
          state_nxt = wmc_pkg::ST_SLOW_HF_STOPPED;
      wmc_pkg::ST_SLOW_HALT:
        if (fall_w[wmc_pkg::SRC_TB])
          state_nxt = wmc_pkg::ST_SLOW_HF_STOPPED;
      default:
        state_nxt = wmc_pkg::ST_S_RUN;
    endcase
  end

  logic halt_in;
  logic halt_out;
  assign halt_in  = (state_nxt == wmc_pkg::ST_S_HALT ||
                     state_nxt == wmc_pkg::ST_SLOW_HALT) &&
                    state_nxt != state_r;
  assign halt_out = (state_r == wmc_pkg::ST_S_HALT ||
                     state_r == wmc_pkg::ST_SLOW_HALT) &&
                    state_nxt != state_r;

  // timebase enable is caught at halt entry and reported on return
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= wmc_pkg::ST_S_RUN;
      tben_r  <= 1'b0;
      tbirq_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (halt_in)
        tben_r <= timebase_enable_i;
      tbirq_r <= halt_out & tben_r;
    end
  end

  // status outputs from flops, computed from the next mode and the next hf reference select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_stop_o       <= 1'b0;
      wdt_stop_o       <= 1'b0;
      periph_gate_o    <= 1'b0;
      prescaler_stop_o <= 1'b0;
      mc_from_lf_o     <= 1'b0;
      hf_pins_gpio_o   <= 1'b1;
      lf_pins_gpio_o   <= 1'b1;
    end else begin
      cpu_stop_o    <= state_nxt inside {wmc_pkg::ST_S_DOZE,
                        wmc_pkg::ST_S_HALT, wmc_pkg::ST_D_DOZE,
                        wmc_pkg::ST_SLOW_DOZE, wmc_pkg::ST_SLOW_HALT};
      wdt_stop_o    <= state_nxt inside {wmc_pkg::ST_S_DOZE,
                        wmc_pkg::ST_S_HALT, wmc_pkg::ST_D_DOZE,
                        wmc_pkg::ST_SLOW_DOZE, wmc_pkg::ST_SLOW_HALT};
      periph_gate_o <= state_nxt inside {wmc_pkg::ST_S_HALT,
                        wmc_pkg::ST_SLOW_HALT};
      prescaler_stop_o <= is_slow(state_nxt);
      mc_from_lf_o     <= is_slow(state_nxt);
      // internal hf reference frees the crystal pins
      hf_pins_gpio_o <= ~((wr_sc1 && !sc2_r.sck) ?
                          wd[wmc_pkg::SC1_HFSEL] : hfsel_r);
      lf_pins_gpio_o <= is_single(state_nxt);
    end
  end

  assign warmup_done_irq_o  = wirq_r;
  assign timebase_irq_set_o = tbirq_r;
  assign int_hf_osc_en_o    = sc2_r.int_en;
  assign ext_hf_osc_en_o    = sc2_r.ext_en;
  assign lf_osc_en_o        = sc2_r.lf_en;
  assign hf_ref_ext_o       = hfsel_r;

  // checks
  property p_abort;
    @(posedge clk_i) disable iff (rst_i)
    abort_w |=> !busy_r && cnt_r == '0 && !wirq_r;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort did not clear warm-up");

  property p_match;
    @(posedge clk_i) disable iff (rst_i)
    match_w && !abort_w && !start_w |=> wirq_r && !busy_r && cnt_r == '0;
  endproperty
  a_match: assert property (p_match)
    else $error("compare match did not stop and clear");

  property p_irq_pulse;
    @(posedge clk_i) disable iff (rst_i)
    wirq_r |=> !wirq_r;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("warm-up irq longer than one cycle");

  property p_start;
    @(posedge clk_i) disable iff (rst_i)
    start_w |=> busy_r && cnt_r == '0;
  endproperty
  a_start: assert property (p_start)
    else $error("enable rise did not start warm-up");

  property p_no_restart;
    @(posedge clk_i) disable iff (rst_i)
    wr_sc2 && !start_w && !busy_r |=> !busy_r;
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("warm-up started without enable rise");

  property p_hfsel_lock;
    @(posedge clk_i) disable iff (rst_i)
    sc2_r.sck |=> $stable(hfsel_r);
  endproperty
  a_hfsel_lock: assert property (p_hfsel_lock)
    else $error("reference select changed in slow clock");

  property p_halt_exit;
    @(posedge clk_i) disable iff (rst_i)
    state_r == wmc_pkg::ST_S_HALT && fall_w[wmc_pkg::SRC_TB]
    |=> state_r == wmc_pkg::ST_S_RUN ##1 !periph_gate_o;
  endproperty
  a_halt_exit: assert property (p_halt_exit)
    else $error("halt not left on timebase falling edge");

  property p_tb_irq;
    @(posedge clk_i) disable iff (rst_i)
    halt_out && tben_r |=> timebase_irq_set_o ##1 !timebase_irq_set_o;
  endproperty
  a_tb_irq: assert property (p_tb_irq)
    else $error("timebase irq latch not set after halt");

  property p_doze_exit;
    @(posedge clk_i) disable iff (rst_i)
    state_r == wmc_pkg::ST_S_DOZE && irq_pending_i
    |=> state_r == wmc_pkg::ST_S_RUN && !cpu_stop_o;
  endproperty
  a_doze_exit: assert property (p_doze_exit)
    else $error("doze not left on pending interrupt");

  property p_slow_mc;
    @(posedge clk_i) disable iff (rst_i)
    is_slow(state_r) |-> mc_from_lf_o && prescaler_stop_o;
  endproperty
  a_slow_mc: assert property (p_slow_mc)
    else $error("slow mode not on lf machine cycle");

  property p_guard;
    @(posedge clk_i) disable iff (rst_i)
    busy_r && state_r == wmc_pkg::ST_SLOW_HF_STOPPED |=>
    state_r != wmc_pkg::ST_SLOW_HF_RUNNING;
  endproperty
  a_guard: assert property (p_guard)
    else $error("slow mode entered during warm-up");

  c_done:  cover property (@(posedge clk_i) disable iff (rst_i) wirq_r);
  c_abort: cover property (@(posedge clk_i) disable iff (rst_i)
                           abort_w && busy_r);
  c_halt:  cover property (@(posedge clk_i) disable iff (rst_i) halt_out);
  c_slow:  cover property (@(posedge clk_i) disable iff (rst_i)
                           state_r == wmc_pkg::ST_SLOW_HF_STOPPED);

endmodule

// *** wmc_pkg.sv ***
// constants and types for the warm-up counter and operation mode control
package wmc_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFF_WCTL = 8'h00; // warmup_control
  localparam logic [7:0] OFF_WCMP = 8'h04; // warmup_compare_value
  localparam logic [7:0] OFF_SC1  = 8'h08; // system_control_one
  localparam logic [7:0] OFF_SC2  = 8'h0C; // system_control_two
  localparam logic [7:0] OFF_STAT = 8'h10; // status, read only
  // warmup_control fields
  localparam int WCTL_SEL_LSB = 0;
  localparam int WCTL_DIV_LSB = 2;
  localparam int WCTL_ABORT   = 4;
  // system_control_one field
  localparam int SC1_HFSEL = 3;
  // system_control_two fields
  localparam int SC2_INT_EN = 7;
  localparam int SC2_EXT_EN = 6;
  localparam int SC2_LF_EN  = 5;
  localparam int SC2_SCK    = 4;
  localparam int SC2_IDLE   = 3;
  localparam int SC2_HALT   = 2;
  // status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_DUAL = 1;
  localparam int STAT_SLOW = 2;
  localparam int STAT_CNT  = 8;
  // reset values
  localparam logic [1:0] RST_SEL   = 2'h0;
  localparam logic [1:0] RST_DIV   = 2'h3;
  localparam logic [7:0] RST_CMP   = 8'h66;
  localparam logic       RST_HFSEL = 1'h0;
  localparam logic       RST_INTEN = 1'h1;
  // warm-up source codes; index 3 is the timebase source
  localparam logic [1:0] SRC_INT_HF = 2'h0;
  localparam logic [1:0] SRC_EXT_HF = 2'h1;
  localparam logic [1:0] SRC_LF     = 2'h2;
  localparam int         SRC_TB     = 3;
  localparam int         NSYNC      = 4;
  // counter geometry
  localparam int CNT_W  = 14;
  localparam int CMP_W  = 8;
  localparam int PRE_W  = 3;

  typedef enum logic [3:0] {
    ST_S_RUN,    // single_clock_run
    ST_S_DOZE,   // single_clock_doze
    ST_S_HALT,   // single_clock_halt
    ST_D_RUN,    // dual_clock_run
    ST_D_DOZE,   // dual_clock_doze
    ST_SLOW_HF_RUNNING,    // slow_hf_running
    ST_SLOW_HF_STOPPED,    // slow_hf_stopped
    ST_SLOW_DOZE,   // slow_doze
    ST_SLOW_HALT    // slow_halt
  } wmc_mode_t;

  typedef struct packed {
    logic [1:0] div;
    logic [1:0] sel;
  } wmc_wctl_t;

  typedef struct packed {
    logic int_en;
    logic ext_en;
    logic lf_en;
    logic sck;
  } wmc_sc2_t;
endpackage

// *** tb_warmup_and_mode_control.sv ***
// self-checking bench for the warm-up counter and mode controller
module tb_warmup_and_mode_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic int_hf_clk_i, ext_hf_clk_i, lf_clk_i;
  logic tb_src_clk_i = 1'b1, timebase_enable_i = 1'b1, irq_pending_i = 1'b0;
  logic warmup_done_irq_o, timebase_irq_set_o, int_hf_osc_en_o;
  logic ext_hf_osc_en_o, lf_osc_en_o, hf_ref_ext_o, mc_from_lf_o;
  logic cpu_stop_o, wdt_stop_o, periph_gate_o, prescaler_stop_o;
  logic hf_pins_gpio_o, lf_pins_gpio_o;
  logic [3:0] osc_div = 4'h0;
  logic [7:0] q;
  int num_errors = 0, cmp_count = 0, n;

  wmc_top i_dut (
    .clk_i              (clk_i),
    .rst_i              (rst_i),
    .wb_cyc_i           (wb_cyc_i),
    .wb_stb_i           (wb_stb_i),
    .wb_we_i            (wb_we_i),
    .wb_adr_i           (wb_adr_i),
    .wb_sel_i           (wb_sel_i),
    .wb_dat_i           (wb_dat_i),
    .wb_dat_o           (wb_dat_o),
    .wb_ack_o           (wb_ack_o),
    .int_hf_clk_i       (int_hf_clk_i),
    .ext_hf_clk_i       (ext_hf_clk_i),
    .lf_clk_i           (lf_clk_i),
    .tb_src_clk_i       (tb_src_clk_i),
    .timebase_enable_i  (timebase_enable_i),
    .irq_pending_i      (irq_pending_i),
    .warmup_done_irq_o  (warmup_done_irq_o),
    .timebase_irq_set_o (timebase_irq_set_o),
    .int_hf_osc_en_o    (int_hf_osc_en_o),
    .ext_hf_osc_en_o    (ext_hf_osc_en_o),
    .lf_osc_en_o        (lf_osc_en_o),
    .hf_ref_ext_o       (hf_ref_ext_o),
    .mc_from_lf_o       (mc_from_lf_o),
    .cpu_stop_o         (cpu_stop_o),
    .wdt_stop_o         (wdt_stop_o),
    .periph_gate_o      (periph_gate_o),
    .prescaler_stop_o   (prescaler_stop_o),
    .hf_pins_gpio_o     (hf_pins_gpio_o),
    .lf_pins_gpio_o     (lf_pins_gpio_o)
  );

  always #12.5 clk_i = ~clk_i;
  // oscillator stand-ins; each level lasts 4 or 8 clocks, above sync needs
  always @(posedge clk_i) osc_div <= osc_div + 4'h1;
  assign int_hf_clk_i = osc_div[2];
  assign ext_hf_clk_i = osc_div[2];
  assign lf_clk_i = osc_div[3];

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // a bounded wait that ran out ends the run at once
  task automatic tmo(input logic ok);
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      give_verdict();
    end
  endtask

  // classic wishbone single cycle, held until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    n = 0;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= {24'h000000, d};
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    tmo(wb_ack_o);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    wb(a, 1'b0, 8'h00);
    chk({24'h0, q}, {24'h0, exp});
  endtask

  // counts cycles until the warm-up done pulse, bounded
  task automatic wait_done(input int lim);
    n = 0;
    while (warmup_done_irq_o !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    tmo(warmup_done_irq_o);
  endtask

  task automatic t_reset();
    rd(wmc_pkg::OFF_WCTL, 8'h0C);
    rd(wmc_pkg::OFF_WCMP, 8'h66);
    rd(wmc_pkg::OFF_SC1, 8'h00);
    rd(wmc_pkg::OFF_SC2, 8'h80);
    rd(8'h20, 8'h00);
    chk(32'({int_hf_osc_en_o, hf_ref_ext_o, mc_from_lf_o}), 32'h4);
    chk(32'({hf_pins_gpio_o, lf_pins_gpio_o}), 32'h3);
    chk(32'({cpu_stop_o, wdt_stop_o, periph_gate_o, prescaler_stop_o}),
        32'h0);
    $display("end of reset test");
  endtask

  task automatic t_warmup();
    wb(wmc_pkg::OFF_WCMP, 1'b1, 8'h01);
    wb(wmc_pkg::OFF_WCTL, 1'b1, 8'h01);
    wb(wmc_pkg::OFF_SC2, 1'b1, 8'hC0);
    chk({31'h0, ext_hf_osc_en_o}, 32'h1);
    wait_done(2000);
    // upper byte reaches 1 after 64 source edges, source period 8 clocks
    chk(32'((n > 64 * 8 - 30) && (n < 64 * 8 + 20)), 32'h1);
    @(posedge clk_i);
    chk({31'h0, warmup_done_irq_o}, 32'h0);
    rd(wmc_pkg::OFF_STAT, 8'h00);
    wb(wmc_pkg::OFF_SC2, 1'b1, 8'hC0);
    rd(wmc_pkg::OFF_STAT, 8'h00);
    wb(wmc_pkg::OFF_SC2, 1'b1, 8'h80);
    wb(wmc_pkg::OFF_SC2, 1'b1, 8'hC0);
    rd(wmc_pkg::OFF_STAT, 8'h01);
    wb(wmc_pkg::OFF_WCTL, 1'b1, 8'h11);
    rd(wmc_pkg::OFF_WCTL, 8'h01);
    rd(wmc_pkg::OFF_STAT, 8'h00);
    rd(wmc_pkg::OFF_SC2, 8'hC0);
    chk({31'h0, warmup_done_irq_o}, 32'h0);
    // only one hf oscillator stays on before any mode change
    wb(wmc_pkg::OFF_SC2, 1'b1, 8'h80);
    $display("end of warm-up test");
  endtask

  task automatic t_doze_halt();
    wb(wmc_pkg::OFF_SC2, 1'b1, 8'h88);
    chk(32'({cpu_stop_o, wdt_stop_o, periph_gate_o}), 32'h6);
    irq_pending_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (cpu_stop_o !== 1'b0 && n < 6);
    tmo(~cpu_stop_o);
    irq_pending_i <= 1'b0;
    wb(wmc_pkg::OFF_SC2, 1'b1, 8'h84);
    chk(32'({cpu_stop_o, periph_gate_o, hf_pins_gpio_o}), 32'h7);
    chk({31'h0, timebase_irq_set_o}, 32'h0);
    tb_src_clk_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (periph_gate_o !== 1'b0 && n < 8);
    tmo(~periph_gate_o);
    chk({31'h0, cpu_stop_o}, 32'h0);
    n = 0;
    while (timebase_irq_set_o !== 1'b1 && n < 3) begin
      @(posedge clk_i);
      n++;
    end
    tmo(timebase_irq_set_o);
    tb_src_clk_i <= 1'b1;
    $display("end of doze and halt test");
  endtask

  task automatic t_dual_slow();
    wb(wmc_pkg::OFF_WCTL, 1'b1, 8'h02);
    wb(wmc_pkg::OFF_SC2, 1'b1, 8'hA0);
    // still single-clock while the lf oscillator warms up
    chk(32'({lf_osc_en_o, lf_pins_gpio_o}), 32'h3);
    wait_done(2500);
    repeat (3) @(posedge clk_i);
    chk(32'({lf_pins_gpio_o, mc_from_lf_o}), 32'h0);
    rd(wmc_pkg::OFF_STAT, 8'h02);
    wb(wmc_pkg::OFF_SC2, 1'b1, 8'hB0);
    // the stored slow select moves the mode one cycle after the commit
    @(posedge clk_i);
    chk(32'({mc_from_lf_o, prescaler_stop_o}), 32'h3);
    wb(wmc_pkg::OFF_SC1, 1'b1, 8'h08);
    rd(wmc_pkg::OFF_SC1, 8'h00);
    chk({31'h0, hf_ref_ext_o}, 32'h0);
    // hf off drops to slow with hf stopped; the only slow mode that takes idle
    wb(wmc_pkg::OFF_SC2, 1'b1, 8'h30);
    wb(wmc_pkg::OFF_SC2, 1'b1, 8'h38);
    chk(32'({cpu_stop_o, mc_from_lf_o}), 32'h3);
    irq_pending_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    irq_pending_i <= 1'b0;
    chk({31'h0, cpu_stop_o}, 32'h0);
    // restarting the external hf holds slow with hf stopped until done
    wb(wmc_pkg::OFF_SC2, 1'b1, 8'h70);
    rd(wmc_pkg::OFF_STAT, 8'h07);
    wait_done(2500);
    // now in slow with hf running, where idle is not taken
    wb(wmc_pkg::OFF_SC2, 1'b1, 8'h78);
    chk({31'h0, cpu_stop_o}, 32'h0);
    $display("end of dual and slow test");
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_warmup();
    t_doze_halt();
    t_dual_slow();
    give_verdict();
  end
endmodule
